// file: rtl/pcs_params.svh
// constants for the panel serial command handler
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_CLK_HZ 50000000
`define PCS_BAUD 2400
`define PCS_BIT_CYC (`PCS_CLK_HZ / `PCS_BAUD)
`define PCS_HALF_CYC (`PCS_BIT_CYC / 2)
`define PCS_CMD_RESET 8'h00
`define PCS_CMD_SET 8'h01
`define PCS_CMD_GET 8'h02
`define PCS_CMD_HYST 8'h03
`define PCS_NSW 8
`define PCS_NAD 2
`define PCS_NIND 8
`define PCS_SW_BASE 8'h00
`define PCS_AD_BASE 8'h10
`define PCS_IND_BASE 8'h20
`define PCS_COMM_CODE 8'hF0
`define PCS_NOISE_CODE 8'hF1
`define PCS_DEB_MS 10
`define PCS_DEB_CYC (`PCS_CLK_HZ / 1000 * `PCS_DEB_MS)
`define PCS_NOISE_MS 500
`define PCS_NOISE_CYC (`PCS_CLK_HZ / 1000 * `PCS_NOISE_MS)
`define PCS_NOISE_CONT_MIN 8'h80
`define PCS_HYST_RST 8'h04
`endif

// file: rtl/pcs_pkg.sv
// types for the panel serial command handler
package pcs_pkg;
  typedef enum logic [5:0] {
    P_IDLE = 6'b000001,
    P_CODE = 6'b000010,
    P_DATA = 6'b000100,
    P_SEND = 6'b001000,
    P_SEND2 = 6'b010000,
    P_WAIT = 6'b100000
  } pcs_state_t;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] value;
  } pcs_msg_t;
endpackage : pcs_pkg

// file: rtl/pcs_uart_rx.sv
// serial byte receiver, 8N1 lsb first
`timescale 1ns/100ps
`include "pcs_params.svh"
module pcs_uart_rx
  import pcs_pkg::*;
#(
  parameter int BIT_CYC = `PCS_BIT_CYC // clocks per serial bit
)(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic rxd, // serial line in
  output logic [7:0] data, // received byte
  output logic valid // one-cycle pulse per byte
);
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic busy_q, busy_d;
  logic vld_q, vld_d;

  // sample mid-bit; a start bit that fails its middle sample is noise
  always_comb begin
    cnt_d = cnt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    busy_d = busy_q;
    vld_d = 1'b0;
    if (!busy_q) begin
      if (!rxd) begin
        busy_d = 1'b1;
        cnt_d = 16'(BIT_CYC / 2);
        bit_d = 4'h0;
      end
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end else begin
      cnt_d = 16'(BIT_CYC - 1);
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h0) begin
        if (rxd) busy_d = 1'b0;
      end else if (bit_q < 4'h9) begin
        sh_d = {rxd, sh_q[7:1]};
      end else begin
        busy_d = 1'b0;
        vld_d = rxd; // bad stop bit drops the byte
      end
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      busy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      busy_q <= busy_d;
      vld_q <= vld_d;
    end
  end
  assign data = sh_q;
  assign valid = vld_q;
endmodule : pcs_uart_rx

// file: rtl/pcs_uart_tx.sv
// serial byte transmitter, 8N1 lsb first
`timescale 1ns/100ps
`include "pcs_params.svh"
module pcs_uart_tx
  import pcs_pkg::*;
#(
  parameter int BIT_CYC = `PCS_BIT_CYC // clocks per serial bit
)(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // pulse: send data
  input wire logic [7:0] data, // byte to send
  output logic txd, // serial line out
  output logic busy // high while a frame is on the line
);
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] sh_q, sh_d;
  logic busy_q, busy_d;

  // frame = start, 8 data lsb first, stop
  always_comb begin
    cnt_d = cnt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    busy_d = busy_q;
    if (!busy_q) begin
      if (start) begin
        sh_d = {1'b1, data, 1'b0};
        busy_d = 1'b1;
        cnt_d = 16'(BIT_CYC - 1);
        bit_d = 4'h0;
      end
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end else begin
      cnt_d = 16'(BIT_CYC - 1);
      sh_d = {1'b1, sh_q[9:1]};
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h9) busy_d = 1'b0;
    end
  end

  // registers; idle line is mark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 10'h3FF;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      busy_q <= busy_d;
    end
  end
  assign txd = busy_q ? sh_q[0] : 1'b1;
  assign busy = busy_q;
endmodule : pcs_uart_tx

// file: rtl/pcs_panel.sv
// panel controller: serial command parser, reports and pseudo-devices
`timescale 1ns/100ps
`include "pcs_params.svh"
module pcs_panel
  import pcs_pkg::*;
#(
  parameter logic [7:0] COMM_CODE = `PCS_COMM_CODE,
  parameter logic [7:0] NOISE_CODE = `PCS_NOISE_CODE,
  parameter logic [7:0] NOISE_CONT_MIN = `PCS_NOISE_CONT_MIN,
  parameter int DEB_CYC = `PCS_DEB_CYC,
  parameter int NOISE_CYC = `PCS_NOISE_CYC,
  parameter int BIT_CYC = `PCS_BIT_CYC
)(
  input wire logic REF_CLK, // 50 MHz system clock
  input wire logic RST_N, // async power-on reset, active low
  input wire logic RXD, // serial in from simulation_host
  input wire logic [`PCS_NSW-1:0] SW_IN, // raw switch contacts
  input wire logic [7:0] AD_IN [`PCS_NAD], // A/D control samples
  output logic TXD, // serial out to simulation_host
  output logic [7:0] IND_OUT [`PCS_NIND], // indicator values
  output logic COMM_EN, // comms subsystem enable
  output logic [7:0] NOISE_SEL, // active noise, 0 is silent
  output logic NOISE_ACT // a noise is playing
);
  // serial engines and their handshake
  logic [7:0] rx_data;
  logic rx_vld;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_busy;
  logic txd_w;
  logic txd_q;
  // parser state and the message waiting for the line
  pcs_state_t st_q, st_d;
  logic [7:0] cmd_q, cmd_d;
  pcs_msg_t arg_q, arg_d;
  pcs_msg_t out_q, out_d;
  // settings the host can write and read back
  logic [7:0] ind_q [`PCS_NIND];
  logic [7:0] ind_d [`PCS_NIND];
  logic comm_q, comm_d;
  logic [7:0] noise_q, noise_d;
  logic [31:0] ntmr_q, ntmr_d;
  logic act_q, act_d;
  // change detection; the images hold what the host last heard
  logic [7:0] hyst_q, hyst_d;
  logic [`PCS_NSW-1:0] sw_q, sw_d;
  logic [31:0] deb_q [`PCS_NSW];
  logic [31:0] deb_d [`PCS_NSW];
  logic [7:0] ad_q [`PCS_NAD];
  logic [7:0] ad_d [`PCS_NAD];
  // the reset command only counts in idle, so a code byte 00 is safe
  logic soft_rst;

  // receiver; a byte with a bad stop bit never reaches the parser
  pcs_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .rxd(RXD),
    .data(rx_data),
    .valid(rx_vld)
  );

  // transmitter; busy covers the stop bit so frames never overlap
  pcs_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .start(tx_start),
    .data(tx_data),
    .txd(txd_w),
    .busy(tx_busy)
  );

  // absolute distance, used by the A/D change test
  function automatic logic [7:0] pcs_absdiff(input logic [7:0] a,
                                             input logic [7:0] b);
    pcs_absdiff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction : pcs_absdiff

  // current value of any code; unknown codes read as zero
  function automatic logic [7:0] pcs_lookup(input logic [7:0] n);
    logic [7:0] v;
    v = 8'h00;
    if (n == COMM_CODE) begin
      v = {7'h00, comm_q};
    end else if (n == NOISE_CODE) begin
      v = noise_q;
    end else if (n >= `PCS_SW_BASE && n < `PCS_SW_BASE + `PCS_NSW) begin
      v = {7'h00, sw_q[3'(n - `PCS_SW_BASE)]};
    end else if (n >= `PCS_AD_BASE && n < `PCS_AD_BASE + `PCS_NAD) begin
      v = ad_q[1'(n - `PCS_AD_BASE)];
    end else if (n >= `PCS_IND_BASE && n < `PCS_IND_BASE + `PCS_NIND) begin
      v = ind_q[3'(n - `PCS_IND_BASE)];
    end
    pcs_lookup = v;
  endfunction : pcs_lookup

  assign soft_rst = (st_q == P_IDLE) && rx_vld && rx_data == `PCS_CMD_RESET;

  // parser and sender; a pending change report waits for the line
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    arg_d = arg_q;
    out_d = out_q;
    ind_d = ind_q;
    comm_d = comm_q;
    noise_d = noise_q;
    ntmr_d = ntmr_q;
    hyst_d = hyst_q;
    sw_d = sw_q;
    deb_d = deb_q;
    ad_d = ad_q;
    tx_start = 1'b0;
    tx_data = out_q.code;
    // noise timeout, continuous noises never time out
    if (noise_q != 8'h00 && noise_q < NOISE_CONT_MIN) begin
      if (ntmr_q == 32'h0) noise_d = 8'h00;
      else ntmr_d = ntmr_q - 32'h1;
    end
    // bytes arriving while a message is being sent are lost; the host waits for replies
    case (st_q)
      P_IDLE: begin
        if (rx_vld) begin
          cmd_d = rx_data;
          if (rx_data == `PCS_CMD_SET || rx_data == `PCS_CMD_GET ||
              rx_data == `PCS_CMD_HYST) begin
            st_d = P_CODE;
          end
          // other bytes fall through and are dropped
        end else begin
          // unsolicited reports, first changed A/D then switch
          for (int i = `PCS_NSW - 1; i >= 0; i--) begin
            if (deb_q[i] >= 32'(DEB_CYC)) begin
              out_d.code = 8'(`PCS_SW_BASE + i);
              out_d.value = {7'h00, SW_IN[i]};
              st_d = P_SEND;
            end
          end
          for (int j = `PCS_NAD - 1; j >= 0; j--) begin
            if (pcs_absdiff(AD_IN[j], ad_q[j]) > hyst_q) begin
              out_d.code = 8'(`PCS_AD_BASE + j);
              out_d.value = AD_IN[j];
              st_d = P_SEND;
            end
          end
          if (st_d == P_SEND) begin
            for (int i = 0; i < `PCS_NSW; i++) begin
              if (out_d.code == 8'(`PCS_SW_BASE + i)) begin
                sw_d[i] = SW_IN[i];
                deb_d[i] = 32'h0;
              end
            end
            for (int j = 0; j < `PCS_NAD; j++) begin
              if (out_d.code == 8'(`PCS_AD_BASE + j)) ad_d[j] = AD_IN[j];
            end
          end
        end
      end
      P_CODE: begin
        if (rx_vld) begin
          arg_d.code = rx_data;
          if (cmd_q == `PCS_CMD_GET) begin
            out_d.code = rx_data;
            out_d.value = pcs_lookup(rx_data);
            st_d = P_SEND;
          end else if (cmd_q == `PCS_CMD_HYST) begin
            hyst_d = rx_data;
            st_d = P_IDLE;
          end else begin
            st_d = P_DATA;
          end
        end
      end
      P_DATA: begin
        if (rx_vld) begin
          st_d = P_IDLE;
          // comms ignores any value but 0 and 1
          if (arg_q.code == COMM_CODE) begin
            if (rx_data == 8'h01) comm_d = 1'b1;
            else if (rx_data == 8'h00) comm_d = 1'b0;
          end else if (arg_q.code == NOISE_CODE) begin
            noise_d = rx_data;
            ntmr_d = 32'(NOISE_CYC);
          end else if (arg_q.code >= `PCS_IND_BASE &&
                       arg_q.code < `PCS_IND_BASE + `PCS_NIND) begin
            ind_d[3'(arg_q.code - `PCS_IND_BASE)] = rx_data;
          end
        end
      end
      P_SEND: begin
        // a frame still on the line holds the code byte back
        if (!tx_busy) begin
          tx_start = 1'b1;
          tx_data = out_q.code;
          st_d = P_WAIT;
        end
      end
      P_WAIT: begin
        // value byte leaves right after the code byte's stop bit
        if (!tx_busy) begin
          tx_start = 1'b1;
          tx_data = out_q.value;
          st_d = P_SEND2;
        end
      end
      P_SEND2: begin
        // hold the parser off until the last stop bit is out
        if (!tx_busy) st_d = P_IDLE;
      end
      default: st_d = P_IDLE;
    endcase
    // switch debounce: count while raw differs from reported
    for (int i = 0; i < `PCS_NSW; i++) begin
      if (SW_IN[i] == sw_d[i]) deb_d[i] = 32'h0;
      else if (deb_q[i] < 32'(DEB_CYC)) deb_d[i] = deb_q[i] + 32'h1;
    end
    // flag taken from the next noise value so it never lags the select
    act_d = (noise_d != 8'h00) ? 1'b1 : 1'b0;
  end

  // registers; the reset command clears as power-on does but re-learns the switch and A/D images
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= P_IDLE;
      cmd_q <= 8'h00;
      arg_q <= '0;
      out_q <= '0;
      comm_q <= 1'b0;
      noise_q <= 8'h00;
      ntmr_q <= 32'h0;
      hyst_q <= `PCS_HYST_RST;
      sw_q <= '0;
      txd_q <= 1'b1;
      act_q <= 1'b0;
      for (int i = 0; i < `PCS_NIND; i++) ind_q[i] <= 8'h00;
      for (int i = 0; i < `PCS_NSW; i++) deb_q[i] <= 32'h0;
      for (int j = 0; j < `PCS_NAD; j++) ad_q[j] <= 8'h00;
    end else if (soft_rst) begin
      st_q <= P_IDLE;
      cmd_q <= 8'h00;
      arg_q <= '0;
      out_q <= '0;
      comm_q <= 1'b0;
      noise_q <= 8'h00;
      ntmr_q <= 32'h0;
      hyst_q <= `PCS_HYST_RST;
      sw_q <= SW_IN; // re-learn panel without a report burst
      act_q <= 1'b0;
      txd_q <= txd_w;
      for (int i = 0; i < `PCS_NIND; i++) ind_q[i] <= 8'h00;
      for (int i = 0; i < `PCS_NSW; i++) deb_q[i] <= 32'h0;
      for (int j = 0; j < `PCS_NAD; j++) ad_q[j] <= AD_IN[j];
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      arg_q <= arg_d;
      out_q <= out_d;
      comm_q <= comm_d;
      noise_q <= noise_d;
      ntmr_q <= ntmr_d;
      hyst_q <= hyst_d;
      sw_q <= sw_d;
      txd_q <= txd_w;
      act_q <= act_d;
      ind_q <= ind_d;
      deb_q <= deb_d;
      ad_q <= ad_d;
    end
  end

  // top outputs, all straight from registers
  assign TXD = txd_q;
  assign IND_OUT = ind_q;
  assign COMM_EN = comm_q;
  assign NOISE_SEL = noise_q;
  assign NOISE_ACT = act_q;
endmodule : pcs_panel

// file: verif/pcs_panel_checker.sv
// port assertions for the panel controller, bound to its top module
`timescale 1ns/100ps
`include "pcs_params.svh"
module pcs_panel_checker
  import pcs_pkg::*;
#(
  parameter int NOISE_CYC = 50,
  parameter int BIT_CYC = `PCS_BIT_CYC
)(
  input wire logic REF_CLK, // system clock
  input wire logic RST_N, // async reset, active low
  input wire logic RXD, // serial in
  input wire logic TXD, // serial out
  input wire logic [7:0] IND_OUT [`PCS_NIND], // indicators
  input wire logic COMM_EN, // comms enable
  input wire logic [7:0] NOISE_SEL, // active noise
  input wire logic NOISE_ACT // noise playing
);
  localparam int BIT = BIT_CYC;
  localparam int LOW_MAX = 9 * BIT + 2;
  logic [17:0] lo_q, lo_d, hi_q, hi_d, nz_q, nz_d;
  logic [7:0] sel_q;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // run lengths of line levels and of one timed noise
  always_comb begin
    lo_d = TXD ? 18'h00000 : (&lo_q ? lo_q : lo_q + 18'h00001);
    hi_d = !TXD ? 18'h00000 : (&hi_q ? hi_q : hi_q + 18'h00001);
    nz_d = (NOISE_SEL != 8'h00 && NOISE_SEL < `PCS_NOISE_CONT_MIN &&
            NOISE_SEL == sel_q) ? nz_q + 18'h00001 : 18'h00000;
  end
  // hi starts saturated so a frame right after reset is legal
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lo_q <= 18'h00000;
      hi_q <= 18'h3FFFF;
      nz_q <= 18'h00000;
      sel_q <= 8'h00;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      nz_q <= nz_d;
      sel_q <= NOISE_SEL;
    end
  end
  property p_rst_vals;
    $rose(RST_N) |-> TXD && !COMM_EN && NOISE_SEL == 8'h00 &&
      IND_OUT[1] == 8'h00;
  endproperty
  property p_act;
    NOISE_ACT == (NOISE_SEL != 8'h00);
  endproperty
  property p_start_len;
    $rose(TXD) |-> lo_q >= BIT - 2;
  endproperty
  property p_stop_len;
    $fell(TXD) |-> hi_q >= BIT - 2;
  endproperty
  property p_low_max;
    lo_q <= LOW_MAX;
  endproperty
  property p_ind_cause;
    !$stable(IND_OUT[1]) |-> $past(RXD);
  endproperty
  property p_comm_cause;
    $changed(COMM_EN) |-> $past(RXD) && $past(RXD, 2);
  endproperty
  property p_noise_cause;
    $rose(NOISE_ACT) |-> $past(RXD);
  endproperty
  property p_noise_len;
    nz_q <= NOISE_CYC + 2;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("bad reset values");
  a_act: assert property (p_act)
    else $error("noise flag wrong");
  a_start_len: assert property (p_start_len)
    else $error("short low");
  a_stop_len: assert property (p_stop_len)
    else $error("short high");
  a_low_max: assert property (p_low_max)
    else $error("long low");
  a_ind_cause: assert property (p_ind_cause)
    else $error("ind moved");
  a_comm_cause: assert property (p_comm_cause)
    else $error("comm moved");
  a_noise_cause: assert property (p_noise_cause)
    else $error("noise");
  a_noise_len: assert property (p_noise_len)
    else $error("noise long");
  c_comm: cover property ($rose(COMM_EN));
  c_noise: cover property ($fell(NOISE_ACT));
  c_frame: cover property ($fell(TXD));
endmodule : pcs_panel_checker

bind pcs_panel pcs_panel_checker
  #(.NOISE_CYC(NOISE_CYC), .BIT_CYC(BIT_CYC)) chk_u (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .RXD(RXD), .TXD(TXD),
  .IND_OUT(IND_OUT), .COMM_EN(COMM_EN), .NOISE_SEL(NOISE_SEL),
  .NOISE_ACT(NOISE_ACT));

// file: verif/pcs_host_model.sv
// behavioural simulation_host: serial sender and receiving queue
`timescale 1ns/100ps
`include "pcs_params.svh"
module pcs_host_model #(
  parameter int BIT = `PCS_BIT_CYC // clocks per serial bit
)(
  input wire logic clk, // system clock
  output logic host_txd, // line into the panel
  input wire logic host_rxd // line from the panel
);
  logic [7:0] rx_q [$];
  logic [7:0] rb;
  initial host_txd = 1'b1; // mark level while idle
  // one start, eight data lsb first, one stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      host_txd = fr[i];
      repeat (BIT - 1) @(negedge clk);
    end
  endtask : send_byte
  // sample mid-bit; a frame with a bad stop is dropped, showing as missing
  always begin
    @(negedge clk);
    if (host_rxd === 1'b0) begin
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge clk);
        rb[i] = host_rxd;
      end
      repeat (BIT) @(negedge clk);
      if (host_rxd === 1'b1) rx_q.push_back(rb);
    end
  end
  // bounded wait for one received byte
  task automatic get_byte(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 25 * BIT) begin
      @(negedge clk);
      n++;
    end
    ok = (rx_q.size() != 0);
    b = ok ? rx_q.pop_front() : 8'h00;
  endtask : get_byte
endmodule : pcs_host_model

// file: verif/panel_serial_command_handler_tb.sv
// self-checking bench for the panel controller with a host model
`timescale 1ns/100ps
`include "pcs_params.svh"
module panel_serial_command_handler_tb;
  localparam int DEB = 50;
  localparam int NZ = 400;
  localparam int BIT = 16; // short bit time keeps the run brief
  logic ref_clk, rst_n, rxd, txd, comm_en, noise_act;
  logic [7:0] sw_in, noise_sel;
  logic [7:0] ad_in [`PCS_NAD];
  logic [7:0] ind_out [`PCS_NIND];
  int num_errors, checks_done;
  pcs_panel #(.DEB_CYC(DEB), .NOISE_CYC(NZ), .BIT_CYC(BIT)) dut_u (
    .REF_CLK(ref_clk), .RST_N(rst_n), .RXD(rxd), .SW_IN(sw_in),
    .AD_IN(ad_in), .TXD(txd), .IND_OUT(ind_out), .COMM_EN(comm_en),
    .NOISE_SEL(noise_sel), .NOISE_ACT(noise_act));
  pcs_host_model #(.BIT(BIT)) host_u (
    .clk(ref_clk), .host_txd(rxd), .host_rxd(txd));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // a reply is always code byte then value byte
  task automatic expect_msg(input logic [7:0] code, val);
    logic [7:0] b;
    bit ok;
    for (int i = 0; i < 2; i++) begin
      host_u.get_byte(b, ok);
      if (!ok) begin
        num_errors++;
        $display("[FAIL] reply byte expected %h seen none", i ? val : code);
        tally_and_finish();
      end
      check("reply byte", b, i ? val : code);
    end
  endtask : expect_msg
  task automatic send2(input logic [7:0] a, b);
    host_u.send_byte(a);
    host_u.send_byte(b);
  endtask : send2
  task automatic t_get_first;
    check("comm at start", {7'h00, comm_en}, 8'h00);
    send2(`PCS_CMD_GET, `PCS_COMM_CODE);
    expect_msg(`PCS_COMM_CODE, 8'h00);
    $display("test get_first done");
  endtask : t_get_first
  task automatic t_set_ind;
    host_u.send_byte(`PCS_CMD_SET);
    send2(8'h21, 8'h55);
    host_u.send_byte(`PCS_CMD_SET);
    send2(8'h27, 8'hAA);
    check("indicator 1", ind_out[1], 8'h55);
    check("indicator 7", ind_out[7], 8'hAA);
    send2(`PCS_CMD_GET, 8'h21);
    expect_msg(8'h21, 8'h55);
    $display("test set_ind done");
  endtask : t_set_ind
  task automatic t_comm;
    host_u.send_byte(`PCS_CMD_SET);
    send2(`PCS_COMM_CODE, 8'h01);
    check("comm on", {7'h00, comm_en}, 8'h01);
    host_u.send_byte(`PCS_CMD_SET);
    send2(`PCS_COMM_CODE, 8'h02); // values other than 0 or 1 are ignored
    check("comm kept", {7'h00, comm_en}, 8'h01);
    send2(`PCS_CMD_GET, `PCS_COMM_CODE);
    expect_msg(`PCS_COMM_CODE, 8'h01);
    $display("test comm done");
  endtask : t_comm
  task automatic t_noise;
    host_u.send_byte(`PCS_CMD_SET);
    send2(`PCS_NOISE_CODE, 8'h05);
    check("timed noise", noise_sel, 8'h05);
    repeat (NZ + 10) @(negedge ref_clk);
    check("noise ended", noise_sel, 8'h00);
    check("noise flag", {7'h00, noise_act}, 8'h00);
    host_u.send_byte(`PCS_CMD_SET);
    send2(`PCS_NOISE_CODE, 8'h81);
    repeat (2 * NZ) @(negedge ref_clk);
    check("background noise", noise_sel, 8'h81);
    check("background flag", {7'h00, noise_act}, 8'h01);
    host_u.send_byte(8'h07); // unknown command, no answer expected
    send2(`PCS_CMD_GET, `PCS_NOISE_CODE);
    expect_msg(`PCS_NOISE_CODE, 8'h81);
    host_u.send_byte(`PCS_CMD_RESET);
    check("noise stopped", noise_sel, 8'h00);
    check("comm cleared", {7'h00, comm_en}, 8'h00);
    check("ind cleared", ind_out[1], 8'h00);
    $display("test noise done");
  endtask : t_noise
  task automatic t_switch;
    // glitches shorter than the debounce time must give no report at all
    for (int i = 0; i < 4; i++) begin
      sw_in[3] = 1'b1;
      repeat (DEB / 5) @(negedge ref_clk);
      sw_in[3] = 1'b0;
      repeat (DEB / 5) @(negedge ref_clk);
    end
    repeat (25 * BIT) @(negedge ref_clk);
    check("glitch frames", 8'(host_u.rx_q.size()), 8'h00);
    sw_in[3] = 1'b1;
    expect_msg(8'h03, 8'h01);
    ad_in[1] = 8'h02; // inside the default hysteresis
    repeat (11 * BIT) @(negedge ref_clk);
    check("extra frames", 8'(host_u.rx_q.size()), 8'h00);
    ad_in[1] = 8'h40;
    expect_msg(8'h11, 8'h40);
    // a wider hysteresis hides a move the default one would report
    send2(`PCS_CMD_HYST, 8'h10);
    ad_in[1] = 8'h48;
    repeat (25 * BIT) @(negedge ref_clk);
    check("hyst frames", 8'(host_u.rx_q.size()), 8'h00);
    ad_in[1] = 8'h60;
    expect_msg(8'h11, 8'h60);
    $display("test switch done");
  endtask : t_switch
  initial begin
    num_errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    sw_in = 8'h00;
    ad_in[0] = 8'h00;
    ad_in[1] = 8'h00;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_get_first();
    t_set_ind();
    t_comm();
    t_noise();
    t_switch();
    tally_and_finish();
  end
endmodule : panel_serial_command_handler_tb
